//--- rtl/xdrd_decoder.sv
// xdrd_decoder: decodes core external-data moves to sram, lock byte, reserved or port bus
// assumes the core holds req for one cycle per move and waits for done_o
`timescale 1ns/100ps
module xdrd_decoder (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // special-function register bus
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    // external-data move from the core
    input wire xdrd_pkg::xdrd_req_s move_i,
    output logic [7:0] move_rdata_o,
    output logic move_done_o,
    // programmed security lock bits three..one
    input wire logic [2:0] security_lock_bits_i,
    // off-chip cycle request to the port sequencer
    output xdrd_pkg::xdrd_ext_s ext_o,
    input wire logic ext_done_i,
    input wire logic [7:0] ext_rdata_i
);

    logic [7:0] pmc_r;
    logic [7:0] sram_r [xdrd_pkg::SRAM_DEPTH];
    logic [7:0] sfr_rdata_r;
    logic [7:0] rdata_r;
    logic done_r;
    logic busy_r;
    xdrd_pkg::xdrd_ext_s ext_r;
    xdrd_pkg::xdrd_map_e map_nxt;
    logic dmap_sel_hi;
    logic dmap_sel_lo;
    logic in_sram;

    assign dmap_sel_hi = pmc_r[xdrd_pkg::SEL_HI_BIT];
    assign dmap_sel_lo = pmc_r[xdrd_pkg::SEL_LO_BIT];
    assign in_sram = (move_i.addr <= xdrd_pkg::SRAM_LAST);

    // region decode, live on the current select bits
    always_comb begin
        map_nxt = xdrd_pkg::XDRD_MAP_EXT;
        unique case ({dmap_sel_hi, dmap_sel_lo})
            2'b00: map_nxt = xdrd_pkg::XDRD_MAP_EXT;
            2'b01: map_nxt = in_sram ? xdrd_pkg::XDRD_MAP_SRAM
                                     : xdrd_pkg::XDRD_MAP_EXT;
            2'b10: map_nxt = xdrd_pkg::XDRD_MAP_RSVD;
            2'b11: begin
                if (in_sram) begin
                    map_nxt = xdrd_pkg::XDRD_MAP_SRAM;
                end else if (move_i.addr == xdrd_pkg::LOCK_ADDR) begin
                    map_nxt = xdrd_pkg::XDRD_MAP_LOCK;
                end else begin
                    map_nxt = xdrd_pkg::XDRD_MAP_RSVD;
                end
            end
        endcase
    end

    // power management register, only its select and stretch fields act here
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pmc_r <= xdrd_pkg::PMC_RESET;
        end else if (sfr_wr_i && sfr_addr_i == xdrd_pkg::PMC_ADDR) begin
            pmc_r <= sfr_wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sfr_rdata_r <= 8'h00;
        end else begin
            sfr_rdata_r <= (sfr_addr_i == xdrd_pkg::PMC_ADDR) ? pmc_r : 8'h00;
        end
    end

    // on-chip sram, no reset: contents are battery backed
    always_ff @(posedge sys_clk_i) begin
        if (move_i.req && !busy_r && move_i.wr && map_nxt == xdrd_pkg::XDRD_MAP_SRAM) begin
            sram_r[move_i.addr[7:0]] <= move_i.wdata;
        end
    end

    // move sequencing: internal regions answer next cycle, external waits for the port
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_r <= 1'b0;
            rdata_r <= 8'h00;
            busy_r <= 1'b0;
            ext_r <= '0;
        end else begin
            done_r <= 1'b0;
            ext_r.req <= 1'b0;
            if (busy_r) begin
                if (ext_done_i) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                    rdata_r <= ext_rdata_i;
                end
            end else if (move_i.req) begin
                unique case (map_nxt)
                    xdrd_pkg::XDRD_MAP_SRAM: begin
                        done_r <= 1'b1;
                        rdata_r <= sram_r[move_i.addr[7:0]];
                    end
                    xdrd_pkg::XDRD_MAP_LOCK: begin
                        done_r <= 1'b1;
                        rdata_r <= {5'h00, security_lock_bits_i};
                    end
                    xdrd_pkg::XDRD_MAP_RSVD: begin
                        done_r <= 1'b1;
                        rdata_r <= xdrd_pkg::RSVD_READ;
                    end
                    xdrd_pkg::XDRD_MAP_EXT: begin
                        busy_r <= 1'b1;
                        ext_r.req <= 1'b1;
                        ext_r.wr <= move_i.wr;
                        ext_r.addr <= move_i.addr;
                        ext_r.wdata <= move_i.wdata;
                        ext_r.stretch <= pmc_r[xdrd_pkg::STRETCH_LSB +: xdrd_pkg::STRETCH_W];
                    end
                endcase
            end
        end
    end

    assign sfr_rdata_o = sfr_rdata_r;
    assign move_rdata_o = rdata_r;
    assign move_done_o = done_r;
    assign ext_o = ext_r;

    property p_sram_fast;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (move_i.req && !busy_r && map_nxt == xdrd_pkg::XDRD_MAP_SRAM) |=> move_done_o && !ext_o.req;
    endproperty
    AST_SRAM_FAST: assert property (p_sram_fast) else $error("sram move not done next cycle");

    AST_RSVD_NOBUS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (move_i.req && !busy_r && dmap_sel_hi && !dmap_sel_lo) |=> !ext_o.req && move_done_o
        && move_rdata_o == xdrd_pkg::RSVD_READ)
        else $error("reserved select produced bus cycle");

    AST_LOCK_READ: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (move_i.req && !busy_r && dmap_sel_hi && dmap_sel_lo && move_i.addr == xdrd_pkg::LOCK_ADDR)
        |=> move_rdata_o[2:0] == $past(security_lock_bits_i) && !ext_o.req)
        else $error("lock byte mismatch");

    AST_HIGH_EXT: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (move_i.req && !busy_r && !dmap_sel_hi && move_i.addr > xdrd_pkg::SRAM_LAST) |=> ext_o.req)
        else $error("high address not sent off-chip");

    AST_ALL_EXT: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (move_i.req && !busy_r && pmc_r[1:0] == 2'b00) |=> ext_o.req && !move_done_o)
        else $error("disabled sram not transparent");

    AST_SRAM_LOW: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (move_i.req && !busy_r && dmap_sel_lo && move_i.addr <= xdrd_pkg::SRAM_LAST) |=> !ext_o.req)
        else $error("low address went off-chip");

    AST_SEL_WRITE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (sfr_wr_i && sfr_addr_i == xdrd_pkg::PMC_ADDR) |=> pmc_r[1:0] == $past(sfr_wdata_i[1:0]))
        else $error("select bits not updated");

    AST_RSVD_HIGH: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (move_i.req && !busy_r && dmap_sel_hi && dmap_sel_lo && move_i.addr > xdrd_pkg::SRAM_LAST
        && move_i.addr != xdrd_pkg::LOCK_ADDR) |=> !ext_o.req ##1 !ext_o.req)
        else $error("reserved region produced bus cycle");

    // named steps of a move, shared by the properties below
    sequence s_taken;
        move_i.req && !busy_r;
    endsequence

    sequence s_taken_ext;
        s_taken ##0 (map_nxt == xdrd_pkg::XDRD_MAP_EXT);
    endsequence

    sequence s_taken_sram;
        s_taken ##0 (map_nxt == xdrd_pkg::XDRD_MAP_SRAM);
    endsequence

    sequence s_taken_lock;
        s_taken ##0 (map_nxt == xdrd_pkg::XDRD_MAP_LOCK);
    endsequence

    sequence s_taken_rsvd;
        s_taken ##0 (map_nxt == xdrd_pkg::XDRD_MAP_RSVD);
    endsequence

    // an off-chip cycle starts without finishing the move
    sequence s_launch;
        ext_o.req && !move_done_o;
    endsequence

    // a locally answered move never touches the port bus
    sequence s_answer_local;
        move_done_o && !ext_o.req;
    endsequence

    AST_EXT_LAUNCH: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_taken_ext |=> s_launch)
        else $error("external move not launched");

    AST_EXT_FIELDS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_taken_ext |=> ext_o.addr == $past(move_i.addr) && ext_o.wr == $past(move_i.wr)
        && ext_o.wdata == $past(move_i.wdata))
        else $error("port cycle fields differ from move");

    AST_EXT_STRETCH: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_taken_ext |=> ext_o.stretch
        == $past(pmc_r[xdrd_pkg::STRETCH_LSB +: xdrd_pkg::STRETCH_W]))
        else $error("stretch field not passed to port");

    AST_EXT_PULSE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ext_o.req |=> !ext_o.req)
        else $error("port request longer than one cycle");

    AST_EXT_BUSY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ext_o.req |-> busy_r)
        else $error("port request while idle");

    AST_EXT_DONE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (busy_r && ext_done_i) |=> move_done_o && !busy_r
        && move_rdata_o == $past(ext_rdata_i))
        else $error("port answer not returned");

    AST_BUSY_REFUSE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (busy_r && !ext_done_i) |=> !move_done_o && !ext_o.req)
        else $error("move taken while port busy");

    AST_SRAM_ANSWER: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_taken_sram |=> s_answer_local)
        else $error("sram move stretched");

    AST_SRAM_WRITE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_taken_sram ##0 move_i.wr |=> sram_r[$past(move_i.addr[7:0])] == $past(move_i.wdata))
        else $error("sram write lost");

    AST_SRAM_READ: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_taken_sram ##0 !move_i.wr |=> move_rdata_o == $past(sram_r[move_i.addr[7:0]]))
        else $error("sram read wrong byte");

    AST_LOCK_UPPER: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_taken_lock |=> s_answer_local ##0 move_rdata_o[7:3] == 5'h00)
        else $error("lock byte upper bits not zero");

    AST_LOCK_BITS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_taken_lock |=> move_rdata_o[2:0] == $past(security_lock_bits_i))
        else $error("lock bits not reflected");

    AST_LOCK_WRITE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_taken_lock ##0 move_i.wr |=> s_answer_local)
        else $error("write to lock byte left the chip");

    AST_RSVD_ANSWER: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_taken_rsvd |=> s_answer_local ##0 move_rdata_o == xdrd_pkg::RSVD_READ)
        else $error("reserved move not answered locally");

    AST_RSVD_RANGE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_taken ##0 (dmap_sel_hi && dmap_sel_lo && move_i.addr > xdrd_pkg::SRAM_LAST
        && move_i.addr != xdrd_pkg::LOCK_ADDR) |-> map_nxt == xdrd_pkg::XDRD_MAP_RSVD)
        else $error("reserved range decoded wrongly");

    AST_MODE01_HIGH: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_taken ##0 (!dmap_sel_hi && dmap_sel_lo && move_i.addr > xdrd_pkg::SRAM_LAST)
        |=> s_launch)
        else $error("high move in sram mode stayed inside");

    AST_IDLE_QUIET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (!busy_r && !move_i.req) |=> !move_done_o && !ext_o.req)
        else $error("activity without a move");

    AST_DONE_IDLE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        move_done_o |-> !busy_r)
        else $error("done while port busy");

    AST_SFR_READ: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (sfr_addr_i == xdrd_pkg::PMC_ADDR) |=> sfr_rdata_o == $past(pmc_r))
        else $error("map register read wrong");

    AST_SFR_OTHER: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (sfr_addr_i != xdrd_pkg::PMC_ADDR) |=> sfr_rdata_o == 8'h00)
        else $error("unmapped sfr read not zero");

    AST_SEL_HOLD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !(sfr_wr_i && sfr_addr_i == xdrd_pkg::PMC_ADDR) |=> $stable(pmc_r))
        else $error("map register changed without write");

endmodule : xdrd_decoder

//--- rtl/xdrd_pkg.sv
// xdrd_pkg: constants and carriers for the external-data region decoder
// assumes a single core clock domain and an 8-bit special-function bus
package xdrd_pkg;
    localparam logic [7:0] PMC_ADDR = 8'hC4;
    localparam logic [7:0] PMC_RESET = 8'h40;
    localparam int SEL_LO_BIT = 0;
    localparam int SEL_HI_BIT = 1;
    localparam logic [15:0] SRAM_LAST = 16'h00FF;
    localparam logic [15:0] LOCK_ADDR = 16'hFFFC;
    localparam logic [7:0] RSVD_READ = 8'hFF;
    localparam int SRAM_DEPTH = 256;
    localparam int STRETCH_W = 3;
    localparam logic [2:0] STRETCH_RESET = 3'h1;
    localparam int STRETCH_LSB = 2;

    typedef enum logic [1:0] {
        XDRD_MAP_EXT,
        XDRD_MAP_SRAM,
        XDRD_MAP_RSVD,
        XDRD_MAP_LOCK
    } xdrd_map_e;

    // one external-data move request from the core
    typedef struct packed {
        logic req;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } xdrd_req_s;

    // one off-chip bus cycle handed to the port 0/2 sequencer
    typedef struct packed {
        logic req;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [2:0] stretch;
    } xdrd_ext_s;
endpackage : xdrd_pkg

//--- test/xdata_region_decoder_test.sv
// xdata_region_decoder_test: random and corner external-data moves in every map mode
// assumes the port model answers every off-chip cycle; sfr address rests at the map register
`timescale 1ns/100ps
module xdata_region_decoder_test;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sfr_wr = 1'b0;
    logic [7:0] sfr_addr = 8'hC4;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata, rdata, ext_rdata, pmc;
    logic [2:0] lock = 3'h0;
    logic done, ext_done;
    xdrd_pkg::xdrd_req_s mv = '0;
    xdrd_pkg::xdrd_ext_s ext;
    logic [7:0] shadow [256];
    logic [15:0] corner [8] = '{16'h0000, 16'h00FF, 16'h0100, 16'hFFFB, 16'hFFFC, 16'hFFFD,
        16'hFFFF, 16'h0042};
    logic [31:0] seed = 32'h0000_0042;
    int fails = 0;
    int total_checks = 0;
    xdrd_decoder i_dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .sfr_wr_i(sfr_wr),
        .sfr_addr_i(sfr_addr), .sfr_wdata_i(sfr_wdata), .sfr_rdata_o(sfr_rdata), .move_i(mv),
        .move_rdata_o(rdata), .move_done_o(done), .security_lock_bits_i(lock), .ext_o(ext),
        .ext_done_i(ext_done), .ext_rdata_i(ext_rdata));
    xdrd_port_model i_port (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .ext_i(ext),
        .done_o(ext_done), .rdata_o(ext_rdata));
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // 0 external, 1 sram, 2 reserved, 3 lock byte
    function automatic logic [1:0] kind(logic [1:0] m, logic [15:0] a);
        if (m == 2'h0) return 2'h0;
        if (a <= 16'h00FF) return (m == 2'h2) ? 2'h2 : 2'h1;
        if (m == 2'h1) return 2'h0;
        return (m == 2'h3 && a == 16'hFFFC) ? 2'h3 : 2'h2;
    endfunction : kind
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        if (fails == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    task automatic move(logic wr, logic [15:0] a, logic [7:0] d);
        logic [1:0] k;
        logic seen;
        logic [7:0] exp;
        logic [31:0] rl;
        int n;
        k = kind(pmc[1:0], a);
        seen = 1'b0;
        n = 0;
        @(posedge sys_clk);
        mv <= '{1'b1, wr, a, d};
        rl = rnd();
        lock <= rl[2:0];
        @(posedge sys_clk);
        mv.req <= 1'b0;
        while (n < 20) begin
            @(negedge sys_clk);
            if (ext.req === 1'b1) begin
                seen = 1'b1;
                check("ext addr", ext.addr, a);
                check("stretch", ext.stretch, pmc[4:2]);
            end
            if (done === 1'b1) break;
            n++;
        end
        check("done", done, 1'b1);
        check("external", seen, k == 2'h0);
        if (k != 2'h0) check("latency", n, 0);
        case (k)
            2'h0: exp = a[7:0] ^ a[15:8];
            2'h1: exp = shadow[a[7:0]];
            2'h2: exp = 8'hFF;
            default: exp = {5'h00, lock};
        endcase
        if (!wr) check("read data", rdata, exp);
        if (wr && k == 2'h1) shadow[a[7:0]] = d;
    endtask : move
    initial begin
        #(20000 * 50);
        fails++;
        end_sim();
    end
    initial begin
        logic [31:0] r;
        pmc = 8'h40;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        sfr_addr <= 8'hC5;
        @(negedge sys_clk);
        check("map reset", sfr_rdata, 8'h40);
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        check("unmapped sfr", sfr_rdata, 8'h00);
        @(posedge sys_clk);
        sfr_addr <= 8'hC4;
        for (int m = -1; m < 4; m++) begin
            if (m >= 0) begin
                r = rnd();
                pmc = {3'h0, r[4:2], m[1:0]};
                @(posedge sys_clk);
                sfr_wr <= 1'b1;
                sfr_wdata <= pmc;
                @(posedge sys_clk);
                sfr_wr <= 1'b0;
                @(posedge sys_clk);
                @(negedge sys_clk);
                check("map reg", sfr_rdata, pmc);
            end
            // fill the sram once so later reads never meet unknown bytes
            if (m == 1) begin
                for (int i = 0; i < 256; i++) begin
                    r = rnd();
                    move(1'b1, {8'h00, i[7:0]}, r[7:0]);
                end
            end
            for (int i = 0; i < 40; i++) begin
                r = rnd();
                move(r[9], r[10] ? corner[r[2:0]] : (r[8] ? {8'h00, r[7:0]} : r[31:16]), r[23:16]);
            end
        end
        end_sim();
    end
endmodule : xdata_region_decoder_test

//--- test/xdrd_port_model.sv
// xdrd_port_model: off-chip memory on ports 0 and 2, answers after 1 to 4 cycles
// assumes ext_i requests arrive one at a time; writes are accepted and dropped
`timescale 1ns/100ps
module xdrd_port_model (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // port bus cycle
    input wire xdrd_pkg::xdrd_ext_s ext_i,
    output logic done_o,
    output logic [7:0] rdata_o
);
    logic [2:0] wait_r;
    logic [15:0] addr_r;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_r <= 3'h0;
            addr_r <= 16'h0000;
            done_o <= 1'b0;
            rdata_o <= 8'h00;
        end else begin
            done_o <= (wait_r == 3'h1);
            rdata_o <= (wait_r == 3'h1) ? addr_r[7:0] ^ addr_r[15:8] : ~rdata_o;
            if (ext_i.req) begin
                wait_r <= {1'b0, ext_i.addr[1:0]} + 3'h1;
                addr_r <= ext_i.addr;
            end else if (wait_r != 3'h0) begin
                wait_r <= wait_r - 3'h1;
            end
        end
    end
endmodule : xdrd_port_model
